// ---- pmc_pkg.sv ----
// ==========================================================
// Shared constants for the presettable modulo-16 counter
package pmc_pkg;

  localparam int unsigned COUNT_WIDTH = 4;
  localparam logic [COUNT_WIDTH-1:0] COUNT_CLEARED = 4'h0;
  localparam logic [COUNT_WIDTH-1:0] COUNT_STEP = 4'h1;

  // Operating modes, highest precedence first
  typedef enum logic [1:0] {
    PMC_MODE_CLEAR = 2'b00,
    PMC_MODE_LOAD = 2'b01,
    PMC_MODE_COUNT = 2'b10,
    PMC_MODE_HOLD = 2'b11
  } pmc_mode_t;

  localparam pmc_mode_t MODE_AFTER_RESET = PMC_MODE_CLEAR;

endpackage : pmc_pkg

// ---- pmc_count_reg.sv ----
`timescale 1ns/1ps
// ==========================================================
// Count register with build-time choice of clear style
module pmc_count_reg #(
  parameter int unsigned WIDTH = pmc_pkg::COUNT_WIDTH,
  parameter bit ASYNC_CLEAR = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Active-low clear, async only when ASYNC_CLEAR is set
  input wire logic i_clear_n,
  // Next value and held value
  input wire logic [WIDTH-1:0] i_next,
  output logic [WIDTH-1:0] o_value
);

  localparam logic [WIDTH-1:0] CLEARED = WIDTH'(pmc_pkg::COUNT_CLEARED);

  generate
    if (ASYNC_CLEAR) begin : g_async
      // Clear acts without the clock; only a constant is taken here
      always_ff @(posedge i_mclk or negedge i_clear_n) begin
        if (!i_clear_n) begin
          o_value <= CLEARED;
        end else if (i_rst) begin
          o_value <= CLEARED;
        end else begin
          o_value <= i_next;
        end
      end
    end else begin : g_sync
      // Synchronous clear is already folded into i_next
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          o_value <= CLEARED;
        end else begin
          o_value <= i_next;
        end
      end
    end
  endgenerate

endmodule : pmc_count_reg

// ---- pmc_counter.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - The count is a binary value that rises by one per counting edge and wraps from 15 to 0.
// - The count changes only on the rising clock edge, except for the asynchronous clear.
// - Mode precedence is clear, then load, then count, otherwise hold.
// - In the asynchronous build a low clear forces the count to zero at once, overriding all inputs.
// - In the synchronous build a low clear zeroes the count at the next rising edge, over load and count.
// - With clear inactive, a low load enable copies the preset value into the count at the next edge, ignoring both enables.
// - With clear and load inactive, the count rises only when both count enables are high.
// - With clear and load inactive, either count enable low holds the count.
// - Terminal count is the AND of all count bits and the trickle enable.
// ==========================================================
// Presettable modulo-16 up-counter
module pmc_counter #(
  parameter int unsigned WIDTH = pmc_pkg::COUNT_WIDTH,
  parameter bit ASYNC_CLEAR = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Controls, all active low except the enables
  input wire logic i_clear_n,
  input wire logic i_load_enable_n,
  input wire logic i_count_enable_parallel,
  input wire logic i_count_enable_trickle,
  // Preset data
  input wire logic [WIDTH-1:0] i_preset_value,
  // Count and cascade outputs
  output logic [WIDTH-1:0] o_count_value,
  output logic o_terminal_count,
  // Mode applied at the last edge
  output pmc_pkg::pmc_mode_t o_mode
);

  // ==========================================================
  // Constants
  // Each constant is cut to the count width once, here, so that the
  // logic below pads and drops bits only in the increment
  localparam logic [WIDTH-1:0] CLEARED = WIDTH'(pmc_pkg::COUNT_CLEARED);
  localparam logic [WIDTH-1:0] STEP = WIDTH'(pmc_pkg::COUNT_STEP);
  localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};

  // ==========================================================
  // Decode helpers

  // A step needs both enables; the trickle enable also gates the carry
  function automatic logic pmc_count_allowed(
    input logic enable_parallel,
    input logic enable_trickle
  );
    return enable_parallel && enable_trickle;
  endfunction : pmc_count_allowed

  // True in the last state before the wrap
  function automatic logic pmc_at_last(
    input logic [WIDTH-1:0] value
  );
    return value == ALL_ONES;
  endfunction : pmc_at_last

  // Fixed precedence: clear, then load, then count, otherwise hold
  function automatic pmc_pkg::pmc_mode_t pmc_decode_mode(
    input logic clear_n,
    input logic load_n,
    input logic enable_parallel,
    input logic enable_trickle
  );
    pmc_pkg::pmc_mode_t result;
    if (!clear_n) begin
      result = pmc_pkg::PMC_MODE_CLEAR;
    end else if (!load_n) begin
      result = pmc_pkg::PMC_MODE_LOAD;
    end else if (pmc_count_allowed(enable_parallel, enable_trickle)) begin
      result = pmc_pkg::PMC_MODE_COUNT;
    end else begin
      result = pmc_pkg::PMC_MODE_HOLD;
    end
    return result;
  endfunction : pmc_decode_mode

  // Modulo step: the carry out of the top bit is dropped on purpose
  function automatic logic [WIDTH-1:0] pmc_increment(
    input logic [WIDTH-1:0] value
  );
    logic [WIDTH:0] wide;
    wide = {1'b0, value} + {1'b0, STEP};
    return wide[WIDTH-1:0];
  endfunction : pmc_increment

  // ==========================================================
  // Next state
  pmc_pkg::pmc_mode_t next_mode;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_mode = pmc_decode_mode(
      i_clear_n,
      i_load_enable_n,
      i_count_enable_parallel,
      i_count_enable_trickle
    );
    next_count = o_count_value;
    unique case (next_mode)
      pmc_pkg::PMC_MODE_CLEAR: begin
        // The asynchronous build has cleared already; zero here keeps it
        // cleared for as long as the clear is held
        next_count = CLEARED;
      end
      pmc_pkg::PMC_MODE_LOAD: begin
        next_count = i_preset_value;
      end
      pmc_pkg::PMC_MODE_COUNT: begin
        next_count = pmc_increment(o_count_value);
      end
      pmc_pkg::PMC_MODE_HOLD: begin
        next_count = o_count_value;
      end
    endcase
  end

  // ==========================================================
  // Count register
  pmc_count_reg #(
    .WIDTH(WIDTH),
    .ASYNC_CLEAR(ASYNC_CLEAR)
  ) u_count_reg (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_clear_n(i_clear_n),
    .i_next(next_count),
    .o_value(o_count_value)
  );

  // ==========================================================
  // Mode status
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_mode <= pmc_pkg::MODE_AFTER_RESET;
    end else begin
      o_mode <= next_mode;
    end
  end

  // ==========================================================
  // Terminal count
  // Left combinational on purpose: a register here would cost a cycle of
  // look-ahead in cascades; downstream must sample it, never clock on it.
  assign o_terminal_count = pmc_at_last(o_count_value) & i_count_enable_trickle;

endmodule : pmc_counter

// ---- pmc_counter_sva.sv ----
`timescale 1ns/1ps
// ==========================================================
// Port checker
module pmc_chk #(parameter bit ASYNC_CLEAR = 1'b1) (
  // Clock, reset, controls
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_clear_n,
  input wire logic i_load_enable_n,
  input wire logic i_count_enable_parallel,
  input wire logic i_count_enable_trickle,
  // Data and outputs
  input wire logic [3:0] i_preset_value,
  input wire logic [3:0] o_count_value,
  input wire logic o_terminal_count,
  input wire logic [1:0] o_mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic ctl = i_clear_n && i_load_enable_n;
  // In the asynchronous build a clear between edges zeroes the count early
  wire logic aclr = ASYNC_CLEAR && !i_clear_n;
  sequence s_run;
    ctl && i_count_enable_parallel && i_count_enable_trickle;
  endsequence
  sequence s_hold;
    ctl && !(i_count_enable_parallel && i_count_enable_trickle);
  endsequence
  chk_clear_first: assert property (!i_clear_n |=>
    o_count_value == 4'h0 && o_mode == pmc_pkg::PMC_MODE_CLEAR)
    else $error("clear missed");
  chk_clear_now: assert property (!i_clear_n && ASYNC_CLEAR |-> o_count_value == 4'h0)
    else $error("async clear missed");
  chk_load_copy: assert property (i_clear_n && !i_load_enable_n |=>
    aclr || o_count_value == $past(i_preset_value))
    else $error("load missed");
  chk_count_step: assert property (s_run |=> aclr || o_count_value == $past(o_count_value) + 4'h1)
    else $error("count missed");
  chk_hold_value: assert property (s_hold |=> aclr || $stable(o_count_value))
    else $error("hold missed");
  chk_term_and: assert property (o_terminal_count == (&o_count_value && i_count_enable_trickle))
    else $error("terminal count wrong");
  chk_wrap_zero: assert property (s_run ##0 o_count_value == 4'hf |=> aclr || o_count_value == 4'h0)
    else $error("wrap missed");
  chk_two_steps: assert property (s_run ##1 s_run |=>
    aclr || o_count_value == $past(o_count_value, 2) + 4'h2)
    else $error("steps missed");
endmodule : pmc_chk
bind pmc_counter pmc_chk #(.ASYNC_CLEAR(ASYNC_CLEAR)) i_pmc_chk (.*);

// ---- pmc_stage.sv ----
`timescale 1ns/1ps
// ==========================================================
// Next cascaded stage; carry is an enable, never a clock
module pmc_stage (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_carry,
  output logic [3:0] o_high
);
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_high <= 4'h0;
    else if (i_carry) o_high <= o_high + 4'h1;
  end
endmodule : pmc_stage

// ---- tb_pmc_counter.sv ----
`timescale 1ns/1ps
// ==========================================================
// Bench: rows of {clear_n, load_n, cep, cet}, preset, count, tc
module tb_pmc_counter;
  typedef struct packed {logic [3:0] c; logic [3:0] d; logic [3:0] q; logic t;} pmc_row_t;
  logic clk = 0, rst = 1, clr = 1, ld = 1, count_enable_parallel = 0, count_enable_trickle = 0, tc, tc_s;
  logic [3:0] pre = 4'h0, q, hi, q_s;
  pmc_pkg::pmc_mode_t md, md_s;
  int n_fail = 0, checks = 0;
  pmc_row_t rows [8] = '{'{4'b1000, 4'he, 4'he, 1'b0}, '{4'b1101, 4'h0, 4'he, 1'b0}, '{4'b1110, 4'h0, 4'he, 1'b0},
    '{4'b1111, 4'h0, 4'hf, 1'b1}, '{4'b1111, 4'h0, 4'h0, 1'b0}, '{4'b0011, 4'h9, 4'h0, 1'b0},
    '{4'b1011, 4'h7, 4'h7, 1'b0}, '{4'b0011, 4'h3, 4'h0, 1'b0}};
  pmc_counter i_pmc_counter (.i_mclk(clk), .i_rst(rst), .i_clear_n(clr), .i_load_enable_n(ld),
    .i_count_enable_parallel(count_enable_parallel), .i_count_enable_trickle(count_enable_trickle), .i_preset_value(pre),
    .o_count_value(q), .o_terminal_count(tc), .o_mode(md));
  // Second build with the synchronous clear, same stimulus
  pmc_counter #(.ASYNC_CLEAR(1'b0)) i_pmc_counter_sync (.i_mclk(clk), .i_rst(rst), .i_clear_n(clr),
    .i_load_enable_n(ld), .i_count_enable_parallel(count_enable_parallel), .i_count_enable_trickle(count_enable_trickle), .i_preset_value(pre),
    .o_count_value(q_s), .o_terminal_count(tc_s), .o_mode(md_s));
  pmc_stage i_pmc_stage (.i_mclk(clk), .i_rst(rst), .i_carry(tc), .o_high(hi));
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial forever #5 clk = ~clk;
  // Whole run is about 35 cycles
  initial begin
    #3000 n_fail++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 0;
    check({2'h0, md}, 4'h0);
    foreach (rows[i]) begin
      {clr, ld, count_enable_parallel, count_enable_trickle} = rows[i].c;
      pre = rows[i].d;
      @(posedge clk) #1;
      check(q, rows[i].q);
      check(q_s, rows[i].q);
      check({3'h0, tc}, {3'h0, rows[i].t});
      check({3'h0, tc_s}, {3'h0, rows[i].t});
      @(negedge clk);
    end
    {clr, ld, count_enable_parallel, count_enable_trickle} = 4'b1111;
    @(negedge clk) clr = 0;
    #1 check(q, 4'h0);
    check(q_s, 4'h1);
    @(posedge clk) #1 check(q_s, 4'h0);
    @(negedge clk) clr = 1;
    repeat (16) @(posedge clk);
    #1 check(q, 4'h0);
    check(q_s, 4'h0);
    check({2'h0, md}, {2'h0, pmc_pkg::PMC_MODE_COUNT});
    check(hi, 4'h2);
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1;
    @(posedge clk) #1 check(q, 4'h0);
    check({2'h0, md}, {2'h0, pmc_pkg::MODE_AFTER_RESET});
    @(negedge clk) rst = 0;
    @(posedge clk) #1 check(q, 4'h1);
    conclude();
  end
endmodule : tb_pmc_counter
